// ===== src/gpsl_defs.svh
`ifndef GPSL_DEFS_SVH
`define GPSL_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define GPSL_OFS_OUT        12'h504
`define GPSL_OFS_OUTSET     12'h508
`define GPSL_OFS_OUTCLR     12'h50C
`define GPSL_OFS_IN         12'h510
`define GPSL_OFS_DIR        12'h514
`define GPSL_OFS_DIRSET     12'h518
`define GPSL_OFS_DIRCLR     12'h51C
`define GPSL_OFS_CAPTURE    12'h520
`define GPSL_OFS_HITSEL     12'h524
`define GPSL_OFS_CFG_BASE   12'h700
`define GPSL_OFS_CFG_LAST   12'h77C

// ----------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------
`define GPSL_CFG_MASK       32'h0013_070F
`define GPSL_CFG_RESET      32'h0000_0002
`define GPSL_SENSE_HIGH     2'h2
`define GPSL_SENSE_LOW      2'h3
`define GPSL_PULL_DOWN      2'h1
`define GPSL_PULL_UP        2'h3
`define GPSL_HTRANS_NONSEQ  2'h2
`define GPSL_WORD_ZERO      32'h0000_0000
`define GPSL_MAX_PINS       32

`endif

// ===== src/gpsl_pkg.sv
package gpsl_pkg;

    // ------------------------------------------------------------
    // Per-pin configuration word
    // ------------------------------------------------------------
    typedef struct packed {
        logic [10:0] rsv3;
        logic        analog;
        logic [1:0]  rsv2;
        logic [1:0]  sense;
        logic [4:0]  rsv1;
        logic [2:0]  drive;
        logic [3:0]  rsv0;
        logic [1:0]  pull;
        logic        in_disc;
        logic        dir;
    } gpsl_pin_cfg_s;

    // ------------------------------------------------------------
    // Latched bus address phase
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic        valid;
    } gpsl_ahb_req_s;

    // ------------------------------------------------------------
    // Source of the common detect output
    // ------------------------------------------------------------
    typedef enum logic {
        GPSL_SRC_LEVEL,
        GPSL_SRC_STICKY
    } gpsl_src_e;

endpackage

// ===== src/gpsl_port.sv
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "gpsl_defs.svh"

// What this block does
// - Up to 32 pins, each reached by its own index.
// - Per-pin config: direction, drive, pulls, sense, buffer, analog.
// - Pin configs keep contents across low-power resets; own power-on reset.
// - Sense field picks high-level or low-level detection per pin.
// - Each pin has its own level-hit signal, high while input matches sense.
// - Default mode ORs all level-hit signals into one common detect output.
// - Sensing and detect output keep working in running and off states.
// - Enabling sense on an already matching pin raises its hit at once.
// - Port event only when detect rises from low; none if already high.
// - A rising level-hit sets the capture bit at the pin's index.
// - Clearing a capture bit does nothing while that pin's hit is high.
// - Capture bits clear only by writing 1; writing 0 leaves them.
// - A falling level-hit leaves its capture bit unchanged.
// - Sticky hit signal is high while any capture bit is 1, except for one cycle after any write to the capture register.
// - Sticky hit signal goes low after any capture write; it stays low only once all capture bits are clear.
// - Bits left after a clear give a fresh rising edge on sticky hit.
// - Capture register readable any time, whatever the detect source.
// - Source select picks OR of level hits or the sticky hit signal.
// - Disconnected input buffer hides the pin from input value and sense.
// - Other blocks may override output value and output enable and read pin inputs.
module gpsl_port
    import gpsl_pkg::*;
#(
    parameter int NPINS = `GPSL_MAX_PINS
)(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             por_n,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0]      pin_out,
    output logic [NPINS-1:0]      pin_oe,
    output logic [NPINS-1:0]      pin_pull_up,
    output logic [NPINS-1:0]      pin_pull_down,
    output logic [NPINS-1:0]      analog_pin_input,
    output logic [3*NPINS-1:0]    pin_drive,
    input  wire logic [NPINS-1:0] periph_ovr,
    input  wire logic [NPINS-1:0] periph_out,
    input  wire logic [NPINS-1:0] periph_oe,
    input  wire logic [NPINS-1:0] periph_in_en,
    output logic [NPINS-1:0]      periph_din,
    output logic [NPINS-1:0]      level_hit,
    output logic                  sticky_hit_signal,
    output logic                  port_detect,
    output logic                  port_event
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (NPINS < 1 || NPINS > `GPSL_MAX_PINS) begin : g_bad_npins
        $error("NPINS must lie between 1 and 32");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    gpsl_pin_cfg_s    cfg_reg [NPINS];
    gpsl_ahb_req_s    req_reg;
    gpsl_src_e        hit_source_select;
    logic [NPINS-1:0] out_reg;
    logic [NPINS-1:0] capture_reg;
    logic [NPINS-1:0] hit_reg;
    logic [NPINS-1:0] in_reg;
    logic [31:0]      hrdata_reg;
    logic             sticky_reg;
    logic             detect_reg;
    logic             event_reg;
    logic             readyout_reg;
    logic             hresp_reg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire              take      = hsel & hready &
                                  (htrans == `GPSL_HTRANS_NONSEQ);
    wire [11:0]       a_addr    = haddr[11:0];
    wire              wr        = req_reg.valid & req_reg.write;
    wire [11:0]       w_addr    = req_reg.addr;
    wire [NPINS-1:0]  wdat      = hwdata[NPINS-1:0];

    wire              wr_out    = wr & (w_addr == `GPSL_OFS_OUT);
    wire              wr_outset = wr & (w_addr == `GPSL_OFS_OUTSET);
    wire              wr_outclr = wr & (w_addr == `GPSL_OFS_OUTCLR);
    wire              wr_dir    = wr & (w_addr == `GPSL_OFS_DIR);
    wire              wr_dirset = wr & (w_addr == `GPSL_OFS_DIRSET);
    wire              wr_dirclr = wr & (w_addr == `GPSL_OFS_DIRCLR);
    wire              wr_cap    = wr & (w_addr == `GPSL_OFS_CAPTURE);
    wire              wr_hitsel = wr & (w_addr == `GPSL_OFS_HITSEL);
    wire              wr_cfg    = wr & (w_addr >= `GPSL_OFS_CFG_BASE) &
                                  (w_addr <= `GPSL_OFS_CFG_LAST);
    wire [4:0]        w_idx     = w_addr[6:2];
    wire [4:0]        r_idx     = a_addr[6:2];
    wire              r_cfg     = (a_addr >= `GPSL_OFS_CFG_BASE) &
                                  (a_addr <= `GPSL_OFS_CFG_LAST) &
                                  (r_idx < NPINS);

    // ------------------------------------------------------------
    // Per-pin logic
    // ------------------------------------------------------------
    logic [NPINS-1:0] dir_vec;
    logic [NPINS-1:0] hit_now;
    logic [NPINS-1:0] in_now;
    logic [NPINS-1:0] eff_out;
    logic [NPINS-1:0] eff_oe;
    logic [NPINS-1:0] pu_next;
    logic [NPINS-1:0] pd_next;
    logic [NPINS-1:0] ana_next;
    logic [3*NPINS-1:0] drv_next;

    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        wire       buf_on  = ~cfg_reg[i].in_disc;
        wire [1:0] sns     = cfg_reg[i].sense;
        wire       want_hi = (sns == `GPSL_SENSE_HIGH);
        wire       want_lo = (sns == `GPSL_SENSE_LOW);
        assign dir_vec[i]  = cfg_reg[i].dir;
        assign in_now[i]   = pin_in[i] & buf_on;
        // Pure level compare, no edge needed to fire
        assign hit_now[i]  = buf_on &
                             ((want_hi & pin_in[i]) |
                              (want_lo & ~pin_in[i]));
        assign eff_out[i]  = periph_ovr[i] ? periph_out[i]
                                           : out_reg[i];
        assign eff_oe[i]   = periph_ovr[i] ? periph_oe[i]
                                           : dir_vec[i];
        assign pu_next[i]  = (cfg_reg[i].pull == `GPSL_PULL_UP);
        assign pd_next[i]  = (cfg_reg[i].pull == `GPSL_PULL_DOWN);
        assign ana_next[i] = cfg_reg[i].analog;
        assign drv_next[3*i +: 3] = cfg_reg[i].drive;
    end

    // ------------------------------------------------------------
    // Capture and detect next values
    // ------------------------------------------------------------
    wire [NPINS-1:0] hit_rise  = hit_now & ~hit_reg;
    wire [NPINS-1:0] clr_mask  = wr_cap ? wdat : '0;
    wire [NPINS-1:0] clr_ok    = clr_mask & ~hit_now;
    wire [NPINS-1:0] cap_next  = (capture_reg & ~clr_ok) |
                                 hit_rise;
    // A clear with bits left drops the sticky line for one cycle
    wire             sticky_nx = (|cap_next) & ~wr_cap;
    wire             level_or  = |hit_now;
    wire             detect_nx = (hit_source_select == GPSL_SRC_STICKY)
                                 ? sticky_nx : level_or;
    wire             event_nx  = detect_nx & ~detect_reg;

    wire [NPINS-1:0] out_next  = wr_out    ? wdat :
                                 wr_outset ? (out_reg | wdat) :
                                 wr_outclr ? (out_reg & ~wdat) :
                                 out_reg;
    wire [NPINS-1:0] dir_next  = wr_dir    ? wdat :
                                 wr_dirset ? (dir_vec | wdat) :
                                 wr_dirclr ? (dir_vec & ~wdat) :
                                 dir_vec;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    wire  [31:0] cfg_word = r_cfg ? cfg_reg[r_idx] : `GPSL_WORD_ZERO;

    always_comb begin
        rd_mux = `GPSL_WORD_ZERO;
        case (a_addr)
            `GPSL_OFS_OUT,
            `GPSL_OFS_OUTSET,
            `GPSL_OFS_OUTCLR:  rd_mux[NPINS-1:0] = out_reg;
            `GPSL_OFS_IN:      rd_mux[NPINS-1:0] = in_reg;
            `GPSL_OFS_DIR,
            `GPSL_OFS_DIRSET,
            `GPSL_OFS_DIRCLR:  rd_mux[NPINS-1:0] = dir_vec;
            `GPSL_OFS_CAPTURE: rd_mux[NPINS-1:0] = capture_reg;
            `GPSL_OFS_HITSEL:  rd_mux[0] = hit_source_select;
            default:           rd_mux = cfg_word;
        endcase
    end

    // ------------------------------------------------------------
    // Retained pin configuration
    // ------------------------------------------------------------
    // Only the power-on reset clears these
    for (genvar i = 0; i < NPINS; i++) begin : g_cfg
        wire sel = wr_cfg & (w_idx == i);
        always_ff @(posedge hclk or negedge por_n) begin
            if (!por_n) begin
                cfg_reg[i] <= `GPSL_CFG_RESET;
            end else if (sel) begin
                cfg_reg[i] <= hwdata & `GPSL_CFG_MASK;
            end else begin
                cfg_reg[i].dir <= dir_next[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Bus slave registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_reg      <= '0;
            hrdata_reg   <= `GPSL_WORD_ZERO;
            readyout_reg <= 1'b0;
            hresp_reg    <= 1'b0;
        end else begin
            hresp_reg     <= 1'b0;
            req_reg.valid <= take;
            req_reg.write <= hwrite;
            req_reg.addr  <= a_addr;
            hrdata_reg    <= (take & ~hwrite) ? rd_mux
                                              : `GPSL_WORD_ZERO;
            readyout_reg  <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_reg           <= '0;
            hit_source_select <= GPSL_SRC_LEVEL;
        end else begin
            out_reg <= out_next;
            if (wr_hitsel) begin
                hit_source_select <= gpsl_src_e'(hwdata[0]);
            end
        end
    end

    // ------------------------------------------------------------
    // Sense, capture and detect
    // ------------------------------------------------------------
    // No gating by power state, so sensing runs in every state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hit_reg     <= '0;
            capture_reg <= '0;
            sticky_reg  <= 1'b0;
            detect_reg  <= 1'b0;
            event_reg   <= 1'b0;
            in_reg      <= '0;
        end else begin
            hit_reg     <= hit_now;
            capture_reg <= cap_next;
            sticky_reg  <= sticky_nx;
            detect_reg  <= detect_nx;
            event_reg   <= event_nx;
            in_reg      <= in_now;
        end
    end

    // ------------------------------------------------------------
    // Pad and peripheral outputs
    // ------------------------------------------------------------
    logic [NPINS-1:0]   pout_reg;
    logic [NPINS-1:0]   poe_reg;
    logic [NPINS-1:0]   pu_reg;
    logic [NPINS-1:0]   pd_reg;
    logic [NPINS-1:0]   ana_reg;
    logic [NPINS-1:0]   pdin_reg;
    logic [3*NPINS-1:0] drv_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pout_reg <= '0;
            poe_reg  <= '0;
            pu_reg   <= '0;
            pd_reg   <= '0;
            ana_reg  <= '0;
            pdin_reg <= '0;
            drv_reg  <= '0;
        end else begin
            pout_reg <= eff_out;
            poe_reg  <= eff_oe;
            pu_reg   <= pu_next;
            pd_reg   <= pd_next;
            ana_reg  <= ana_next;
            pdin_reg <= pin_in & (periph_in_en | ~dir_vec);
            drv_reg  <= drv_next;
        end
    end

    assign hrdata            = hrdata_reg;
    assign hreadyout         = readyout_reg;
    assign hresp             = hresp_reg;
    assign pin_out           = pout_reg;
    assign pin_oe            = poe_reg;
    assign pin_pull_up       = pu_reg;
    assign pin_pull_down     = pd_reg;
    assign analog_pin_input  = ana_reg;
    assign pin_drive         = drv_reg;
    assign periph_din        = pdin_reg;
    assign level_hit         = hit_reg;
    assign sticky_hit_signal = sticky_reg;
    assign port_detect       = detect_reg;
    assign port_event        = event_reg;

endmodule

// ===== sim/gpsl_port_chk.sv
`timescale 1ns/1ps
`include "gpsl_defs.svh"
// ----------------------------------------
// Sense, capture and bus checks
// ----------------------------------------
module gpsl_port_chk #(
    parameter int NPINS = 32
)(
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hsel,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic [NPINS-1:0] level_hit,
    input wire logic             sticky_hit_signal,
    input wire logic             port_detect,
    input wire logic             port_event
);
    logic [1:0] dp_reg;
    wire        take = hsel & hready & (htrans == `GPSL_HTRANS_NONSEQ);
    wire        hit = |level_hit;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            dp_reg <= 2'h0;
        else
            dp_reg <= take ? {hwrite, !hwrite} : 2'h0;
    end
    property p_det;
        port_detect == hit || port_detect == sticky_hit_signal;
    endproperty
    a_det: assert property (p_det)
        else $error("detect follows no source");
    property p_ev;
        port_event == $rose(port_detect);
    endproperty
    a_ev: assert property (p_ev)
        else $error("event not tied to detect rise");
    property p_ev1;
        port_event |=> !port_event;
    endproperty
    a_ev1: assert property (p_ev1)
        else $error("event longer than one cycle");
    property p_set;
        |(level_hit & ~$past(level_hit)) |-> sticky_hit_signal;
    endproperty
    a_set: assert property (p_set)
        else $error("hit rise did not set sticky");
    property p_fall;
        $fell(sticky_hit_signal) |-> $past(dp_reg[1]);
    endproperty
    a_fall: assert property (p_fall)
        else $error("sticky fell without a write");
    property p_rel;
        $fell(sticky_hit_signal) && hit |=> sticky_hit_signal;
    endproperty
    a_rel: assert property (p_rel)
        else $error("sticky not raised again");
    property p_hold;
        hit |-> sticky_hit_signal || $fell(sticky_hit_signal);
    endproperty
    a_hold: assert property (p_hold)
        else $error("hit high but sticky low");
    property p_rd;
        !dp_reg[0] |-> hrdata == 32'h0000_0000;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read data outside data phase");
endmodule
bind gpsl_port gpsl_port_chk #(.NPINS(NPINS)) u_chk (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .level_hit, .sticky_hit_signal, .port_detect, .port_event
);

// ===== sim/gpsl_pins_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Outside circuitry at the pins
// ----------------------------------------
module gpsl_pins_model #(
    parameter int NPINS = 32
)(
    input wire logic             hclk,
    input wire logic [NPINS-1:0] ext_en,
    input wire logic [NPINS-1:0] ext_lvl,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pin_pull_up,
    input wire logic [NPINS-1:0] pin_pull_down,
    output logic [NPINS-1:0]     pin_in
);
    logic [NPINS-1:0] noise_reg = '0;
    wire  [NPINS-1:0] flt = pin_pull_up | (~pin_pull_down & noise_reg);
    always @(posedge hclk) noise_reg <= ~noise_reg;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
                  | (~pin_oe & ~ext_en & flt);
endmodule

// ===== sim/tb_gpio_pin_sense_latch.sv
`timescale 1ns/1ps
`include "gpsl_defs.svh"
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module tb_gpio_pin_sense_latch;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        por_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        rd_ph = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] ext_en = 32'hFFFF_FFFF;
    logic [31:0] ext_lvl = 32'h0000_0000;
    logic [31:0] periph_ovr = 32'h0000_0000;
    logic [31:0] periph_out = 32'h0000_0000;
    logic [31:0] periph_oe = 32'h0000_0000;
    logic [31:0] periph_in_en = 32'h0000_0000;
    logic [31:0] hrdata, pin_in, pin_out, pin_oe, periph_din, level_hit;
    logic [31:0] pin_pull_up, pin_pull_down, analog_pin_input;
    logic [95:0] pin_drive;
    logic        hreadyout, hresp, sticky_hit_signal, port_detect;
    logic        port_event;
    logic [31:0] cfgv [32];
    logic [31:0] exp_q [$];
    int          miscompares = 0;
    int          compares = 0;
    int          ev_cnt = 0;
    int          p, q, r, s, t, e0;
    always #5 hclk = ~hclk;
    gpsl_port u_dut (
        .hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down,
        .analog_pin_input, .pin_drive, .periph_ovr, .periph_out,
        .periph_oe, .periph_in_en, .periph_din, .level_hit,
        .sticky_hit_signal, .port_detect, .port_event
    );
    gpsl_pins_model u_pins (
        .hclk, .ext_en, .ext_lvl, .pin_out, .pin_oe, .pin_pull_up,
        .pin_pull_down, .pin_in
    );
    task automatic cmp(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= `GPSL_HTRANS_NONSEQ;
        haddr  <= {20'h00000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0000_0000;
        rd_ph  <= !w;
        if (!w)
            exp_q.push_back(d);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_ph  <= 1'b0;
    endtask
    function automatic logic [11:0] ca(input int i);
        return 12'(`GPSL_OFS_CFG_BASE + 4 * i);
    endfunction
    task print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
            cmp("hrdata", exp_q.pop_front(), hrdata);
            cmp("hresp", 32'h0, 32'(hresp));
        end
        if (port_event === 1'b1)
            ev_cnt++;
    end
    initial begin
        #100000;
        miscompares++;
        print_verdict;
    end
    initial begin
        void'($urandom(70));
        p = $urandom % 32;
        q = (p + 7) % 32;
        r = (p + 13) % 32;
        s = (p + 19) % 32;
        t = (p + 25) % 32;
        tick(4);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        bus(0, ca(31), `GPSL_CFG_RESET);
        bus(0, `GPSL_OFS_CAPTURE, 32'h0000_0000);
        bus(0, 12'h600, 32'h0000_0000);
        for (int i = 0; i < 32; i++) begin
            cfgv[i] = $urandom & `GPSL_CFG_MASK & 32'hFFFC_FFFF;
            bus(1, ca(i), cfgv[i]);
            bus(0, ca(i), cfgv[i]);
        end
        cmp("drive", 32'(cfgv[p][10:8]), 32'(pin_drive[3*p+:3]));
        cmp("analog", 32'(cfgv[p][20]), 32'(analog_pin_input[p]));
        cmp("pull_up", 32'(cfgv[p][3:2] == `GPSL_PULL_UP),
            32'(pin_pull_up[p]));
        cmp("pull_down", 32'(cfgv[p][3:2] == `GPSL_PULL_DOWN),
            32'(pin_pull_down[p]));
        hresetn <= 1'b0;
        tick(2);
        hresetn <= 1'b1;
        bus(0, ca(p), cfgv[p]);
        bus(1, ca(p), 32'h0002_0000);
        ext_lvl[p] <= 1'b1;
        tick(3);
        cmp("hit", 32'h1 << p, level_hit);
        cmp("det", 32'h1, 32'(port_detect));
        ext_lvl[p] <= 1'b0;
        tick(2);
        bus(0, `GPSL_OFS_CAPTURE, 32'h1 << p);
        ext_lvl[q] <= 1'b1;
        bus(1, ca(q), 32'h0003_0000);
        ext_lvl[q] <= 1'b0;
        tick(2);
        bus(1, `GPSL_OFS_CAPTURE, 32'h0000_0000);
        bus(0, `GPSL_OFS_CAPTURE, (32'h1 << p) | (32'h1 << q));
        bus(1, `GPSL_OFS_CAPTURE, 32'h1 << p);
        bus(0, `GPSL_OFS_CAPTURE, 32'h1 << q);
        bus(1, `GPSL_OFS_CAPTURE, 32'h1 << q);
        bus(0, `GPSL_OFS_CAPTURE, 32'h1 << q);
        cmp("sticky", 32'h1, 32'(sticky_hit_signal));
        ext_lvl[q] <= 1'b1;
        tick(2);
        bus(1, `GPSL_OFS_CAPTURE, 32'h1 << q);
        tick(2);
        cmp("sticky", 32'h0, 32'(sticky_hit_signal));
        e0 = ev_cnt;
        ext_lvl[r] <= 1'b1;
        bus(1, ca(r), 32'h0002_0000);
        tick(4);
        cmp("hit", 32'h1 << r, level_hit);
        cmp("events", e0 + 1, ev_cnt);
        ext_lvl[s] <= 1'b1;
        bus(1, ca(s), 32'h0002_0000);
        tick(3);
        cmp("events", e0 + 1, ev_cnt);
        ext_lvl <= ext_lvl & ~((32'h1 << r) | (32'h1 << s));
        bus(1, `GPSL_OFS_HITSEL, 32'h0000_0001);
        bus(0, `GPSL_OFS_HITSEL, 32'h0000_0001);
        tick(2);
        cmp("det", 32'h1, 32'(port_detect));
        bus(1, `GPSL_OFS_CAPTURE, 32'hFFFF_FFFF);
        tick(2);
        cmp("det", 32'h0, 32'(port_detect));
        bus(1, `GPSL_OFS_HITSEL, 32'h0000_0000);
        bus(1, ca(t), 32'h0002_0002);
        ext_lvl[t] <= 1'b1;
        tick(3);
        cmp("hit", 32'h0, level_hit);
        periph_ovr <= 32'h1 << t;
        periph_out <= 32'h1 << t;
        periph_oe <= 32'h1 << t;
        periph_in_en <= 32'h1 << t;
        tick(3);
        cmp("ovr", 32'h1 << t, pin_oe & pin_out & periph_din);
        periph_out <= 32'h0000_0000;
        tick(3);
        cmp("din", 32'h0, periph_din & (32'h1 << t));
        bus(1, `GPSL_OFS_OUTSET, (32'h1 << r) | (32'h1 << s));
        bus(1, `GPSL_OFS_OUTCLR, 32'h1 << s);
        bus(1, `GPSL_OFS_DIR, 32'h1 << r);
        bus(0, `GPSL_OFS_OUT, 32'h1 << r);
        bus(0, `GPSL_OFS_DIR, 32'h1 << r);
        cmp("pin_oe", 32'h1 << r, pin_oe & ~(32'h1 << t));
        cmp("pin_out", 32'h1 << r, pin_out);
        print_verdict;
    end
endmodule
